/* core/multichannel_lane_packer.sv */
// lane packer: spreads one frame of channel samples over parallel lanes and slots
`timescale 1ns/100ps
`default_nettype none

module multichannel_lane_packer #(
    parameter int CLOCK_KHZ = lane_pack_pkg::DEFAULT_CLOCK_KHZ,
    parameter int SAMPLE_KHZ = lane_pack_pkg::DEFAULT_SAMPLE_KHZ,
    parameter int CHANNEL_TOTAL = lane_pack_pkg::DEFAULT_CHANNEL_TOTAL,
    parameter int SAMPLE_WIDTH = lane_pack_pkg::DEFAULT_SAMPLE_WIDTH,
    // derived shape, fixed by the rates and the channel total; the consumer must be built for the same values
    localparam int FOLD_RATIO = lane_pack_pkg::calc_fold_ratio(CLOCK_KHZ, SAMPLE_KHZ),
    localparam int LANES_PER_STREAM = lane_pack_pkg::calc_lanes_per_stream(CLOCK_KHZ, SAMPLE_KHZ),
    localparam int LANE_GROUPS = lane_pack_pkg::calc_lane_groups(CHANNEL_TOTAL, FOLD_RATIO),
    localparam int LANE_TOTAL = LANES_PER_STREAM * LANE_GROUPS,
    localparam int SLOTS_PER_LANE = lane_pack_pkg::calc_slots_per_lane(CHANNEL_TOTAL, LANE_GROUPS)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [CHANNEL_TOTAL-1:0][LANES_PER_STREAM-1:0][SAMPLE_WIDTH-1:0] in_samples,
    output lane_pack_pkg::stream_ctrl_s out_ctrl,
    output logic [LANE_TOTAL-1:0][SAMPLE_WIDTH-1:0] out_lanes,
    output logic [LANE_TOTAL-1:0] out_lane_used,
    output logic out_frame_start,
    output logic out_overrun
);
    import lane_pack_pkg::*;

    // position counter must also hold the fold ratio itself for the compare
    localparam int POS_W = $clog2(FOLD_RATIO + 1);
    localparam logic [POS_W-1:0] LAST_POS = POS_W'(FOLD_RATIO - 1);
    localparam logic [POS_W-1:0] SLOTS_POS = POS_W'(SLOTS_PER_LANE);

    // refuse shapes the slot counter or the arithmetic cannot serve
    generate
        if (CLOCK_KHZ < 1 || SAMPLE_KHZ < 1) begin : g_bad_rate
            $error("clock and sample rates must be positive");
        end
        if (CHANNEL_TOTAL < 1 || SAMPLE_WIDTH < 1) begin : g_bad_shape
            $error("channel total and sample width must be positive");
        end
        if (SLOTS_PER_LANE > CHANNEL_ID_LIMIT) begin : g_bad_slots
            $error("slots per lane exceed the 8-bit slot counter");
        end
    endgenerate

    // the whole state of the block
    typedef struct packed {
        logic [POS_W-1:0] pos;
        logic pend_full;
        logic [CHANNEL_TOTAL-1:0][LANES_PER_STREAM-1:0][SAMPLE_WIDTH-1:0] pend;
        logic act_live;
        logic [LANE_TOTAL-1:0][SLOTS_PER_LANE-1:0][SAMPLE_WIDTH-1:0] act;
        stream_ctrl_s ctrl;
        logic [LANE_TOTAL-1:0][SAMPLE_WIDTH-1:0] lanes;
        logic [LANE_TOTAL-1:0] used;
        logic frame_start;
        logic overrun;
    } state_s;

    state_s state_reg;
    state_s state_next;

    wire logic [LANE_TOTAL-1:0][SLOTS_PER_LANE-1:0][SAMPLE_WIDTH-1:0] layout;
    wire logic [SLOTS_PER_LANE-1:0][LANE_TOTAL-1:0] used_tbl;
    logic [LANE_TOTAL-1:0][SLOTS_PER_LANE-1:0][SAMPLE_WIDTH-1:0] frame_src;
    logic load;
    logic live_eff;
    logic in_frame;

    // static map: group g, sub-lane k, slot s carries sample k of channel g*slots+s;
    // filling group by group keeps the lanes even and leaves the short one last
    generate
        for (genvar g = 0; g < LANE_GROUPS; g++) begin : g_group
            for (genvar k = 0; k < LANES_PER_STREAM; k++) begin : g_sub
                for (genvar s = 0; s < SLOTS_PER_LANE; s++) begin : g_slot
                    localparam int CH = g * SLOTS_PER_LANE + s;
                    localparam int LANE = g * LANES_PER_STREAM + k;
                    if (CH < CHANNEL_TOTAL) begin : g_live
                        assign layout[LANE][s] = in_samples_hold(CH, k);
                        assign used_tbl[s][LANE] = 1'b1;
                    end else begin : g_pad
                        // leftover slot of a short lane, e.g. lane one slot two of five channels
                        assign layout[LANE][s] = '0;
                        assign used_tbl[s][LANE] = 1'b0;
                    end
                end
            end
        end
    endgenerate

    // sample k of channel ch from the frame waiting to go out
    function automatic logic [SAMPLE_WIDTH-1:0] in_samples_hold(input int ch, input int k);
        return state_reg.pend[ch][k];
    endfunction

    // at slot zero the waiting frame is read straight from the map, else the active copy
    assign frame_src = load ? layout : state_reg.act;

    // next state
    always_comb begin
        state_next = state_reg;
        load = (state_reg.pos == '0);
        // free-running frame position; slot zero starts every frame
        if (state_reg.pos == LAST_POS) begin
            state_next.pos = '0;
        end else begin
            state_next.pos = state_reg.pos + POS_W'(1);
        end

        // one frame waits here; a new arrival wins over the slot-zero take
        if (in_valid) begin
            state_next.pend = in_samples;
            state_next.pend_full = 1'b1;
        end else if (load) begin
            state_next.pend_full = 1'b0;
        end
        // a second frame inside one frame time overwrites the first
        state_next.overrun = in_valid && state_reg.pend_full && !load;

        // gaps are whole frames only, since a frame starts only at slot zero
        live_eff = load ? state_reg.pend_full : state_reg.act_live;
        if (load) begin
            // each channel keeps its own slot for the whole frame
            state_next.act = layout;
            state_next.act_live = state_reg.pend_full;
        end
        state_next.frame_start = load && state_reg.pend_full;

        // slots past the last used one are idle cycles of the frame
        in_frame = (state_reg.pos < SLOTS_POS);
        state_next.ctrl.valid = live_eff && in_frame;
        // one counter for every lane; equals the channel number only on the lanes of group zero
        state_next.ctrl.slot = '0;
        if (live_eff && in_frame) begin
            state_next.ctrl.slot = CHANNEL_ID_WIDTH'(state_reg.pos);
        end

        // per-lane copy of the output mux; idle cycles are driven to zero, not held
        for (int l = 0; l < LANE_TOTAL; l++) begin
            state_next.lanes[l] = '0;
            state_next.used[l] = 1'b0;
            if (live_eff && in_frame) begin
                state_next.lanes[l] = frame_src[l][state_reg.pos];
                state_next.used[l] = used_tbl[state_reg.pos][l];
            end
        end
    end

    // state register; reset leaves valid low and the counter at zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign out_ctrl = state_reg.ctrl;
    assign out_lanes = state_reg.lanes;
    assign out_lane_used = state_reg.used;
    assign out_frame_start = state_reg.frame_start;
    assign out_overrun = state_reg.overrun;

endmodule

`default_nettype wire

/* core/lane_pack_pkg.sv */
// constants, carrier type and lane arithmetic shared by the lane packer
// Summary of operation
// - slots per frame is floor(clock rate / sample rate), at least one
// - lanes per channel is ceil(sample rate / clock rate)
// - lane groups is ceil(channel total / slots per frame)
// - total lanes is lanes per channel times lane groups
// - slots used per lane is ceil(channel total / lane groups)
// - slot counter runs from zero to slots per lane minus one with the data
// - slot counter restarts at zero at every frame start
// - one lane: counter is channel number; more lanes: common slot alignment only
// - one slot counter output shared by all lanes
// - one valid bit covers all lanes; out_lane_used flags which lanes carry a channel in each beat
// - five channels in three slots: three on lane zero, two on lane one
// - channels spread evenly; trailing slots of a frame have valid low
// - while valid is low, counter and lane data carry no meaning
// - super-sample: each cycle carries one sample per lane of one channel
// - channels are numbered zero to channel total minus one
// - more channels than slots: several lanes, datapath copied per lane
// - per-channel state recirculates in its own slot of the frame
// - data counts only with valid high; counter is 8-bit unsigned
// - lane total and slots per lane must match across each connection
package lane_pack_pkg;

    localparam int CHANNEL_ID_WIDTH = 8;
    localparam int CHANNEL_ID_LIMIT = 256;
    localparam int DEFAULT_CLOCK_KHZ = 300000;
    localparam int DEFAULT_SAMPLE_KHZ = 100000;
    localparam int DEFAULT_CHANNEL_TOTAL = 5;
    localparam int DEFAULT_SAMPLE_WIDTH = 16;

    // control half of a beat; the data lanes travel beside it
    typedef struct packed {
        logic valid;
        logic [CHANNEL_ID_WIDTH-1:0] slot;
    } stream_ctrl_s;

    // time slots per frame
    function automatic int calc_fold_ratio(input int clock_khz, input int sample_khz);
        int ratio;
        ratio = clock_khz / sample_khz;
        return (ratio < 1) ? 1 : ratio;
    endfunction

    // lanes one channel needs to keep up with its own rate
    function automatic int calc_lanes_per_stream(input int clock_khz, input int sample_khz);
        return (sample_khz + clock_khz - 1) / clock_khz;
    endfunction

    function automatic int calc_lane_groups(input int channel_total, input int fold_ratio);
        return (channel_total + fold_ratio - 1) / fold_ratio;
    endfunction

    function automatic int calc_slots_per_lane(input int channel_total, input int lane_groups);
        return (channel_total + lane_groups - 1) / lane_groups;
    endfunction

endpackage

/* test/lane_pack_props.sv */
// property checker watching the lane packer ports
`timescale 1ns/100ps
`default_nettype none

module lane_pack_props #(
    parameter int CHANNEL_TOTAL = 5,
    parameter int LANE_TOTAL = 2,
    parameter int SLOTS_PER_LANE = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire lane_pack_pkg::stream_ctrl_s out_ctrl,
    input wire logic [LANE_TOTAL-1:0] out_lane_used,
    input wire logic out_frame_start,
    input wire logic out_overrun
);
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_slot_range; out_ctrl.valid |-> out_ctrl.slot < SLOTS_PER_LANE; endproperty
    a_slot_range: assert property (p_slot_range) else $error("slot past lane slot count");
    property p_slot_step; out_ctrl.valid && out_ctrl.slot < SLOTS_PER_LANE - 1
        |=> out_ctrl.valid && out_ctrl.slot == $past(out_ctrl.slot) + 1; endproperty
    a_slot_step: assert property (p_slot_step) else $error("slot did not advance");
    property p_start; out_frame_start |-> out_ctrl.valid && out_ctrl.slot == 0; endproperty
    a_start: assert property (p_start) else $error("frame start off slot zero");
    property p_take; in_valid |-> ##[1:5] out_frame_start; endproperty
    a_take: assert property (p_take) else $error("frame never delivered");
    property p_overrun; out_overrun |-> $past(in_valid); endproperty
    a_overrun: assert property (p_overrun) else $error("overrun without new frame");
    property p_used; out_ctrl.valid |-> out_lane_used[LANE_TOTAL-1]
        == ((LANE_TOTAL - 1) * SLOTS_PER_LANE + out_ctrl.slot < CHANNEL_TOTAL); endproperty
    a_used: assert property (p_used) else $error("last lane use flag wrong");
    property p_lane0; out_ctrl.valid |-> out_lane_used[0]; endproperty
    a_lane0: assert property (p_lane0) else $error("first lane unused");
    property p_quiet; !out_ctrl.valid |-> out_ctrl.slot == 0 && out_lane_used == '0 && !out_frame_start;
    endproperty
    a_quiet: assert property (p_quiet) else $error("idle beat not quiet");
    property p_rise; $rose(out_ctrl.valid) |-> out_frame_start; endproperty
    a_rise: assert property (p_rise) else $error("frame began mid slot");
endmodule

bind multichannel_lane_packer lane_pack_props #(.CHANNEL_TOTAL(CHANNEL_TOTAL), .LANE_TOTAL(LANE_TOTAL),
    .SLOTS_PER_LANE(SLOTS_PER_LANE)) u_props (.clk(clk), .rst(rst), .in_valid(in_valid), .out_ctrl(out_ctrl),
    .out_lane_used(out_lane_used), .out_frame_start(out_frame_start), .out_overrun(out_overrun));
`default_nettype wire

/* test/frame_source.sv */
// upstream frame producer model for the lane packer
`timescale 1ns/100ps
`default_nettype none

module frame_source (
    input wire logic clk,
    input wire logic send,
    input wire logic [15:0] base,
    output logic vld,
    output logic [4:0][0:0][15:0] smp
);
    logic send_seen;
    logic [15:0] base_seen;
    initial begin
        vld = 1'b0;
        smp = '0;
        send_seen = 1'b0;
        base_seen = 16'h0;
    end
    // whole frame in one beat; between frames data toggles so stale values never look live
    // request is taken at the edge itself, so the bench changing it just after cannot race
    always @(posedge clk) begin
        send_seen = send;
        base_seen = base;
        #1;
        vld = send_seen;
        for (int c = 0; c < 5; c++) smp[c][0] = send_seen ? base_seen + 16'(c) : ~smp[c][0];
    end
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the lane packer
`timescale 1ns/100ps
`default_nettype none

module tb;
    import lane_pack_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic send = 1'b0;
    logic [15:0] base = 16'h0;
    logic in_valid;
    logic [4:0][0:0][15:0] in_samples;
    stream_ctrl_s out_ctrl;
    logic [1:0][15:0] out_lanes;
    logic [1:0] out_lane_used;
    logic out_frame_start;
    logic out_overrun;
    int errors = 0;
    int tests_run = 0;

    always #20 clk = ~clk;

    frame_source u_src (.clk(clk), .send(send), .base(base), .vld(in_valid), .smp(in_samples));
    multichannel_lane_packer u_dut (.clk(clk), .rst(rst), .in_valid(in_valid), .in_samples(in_samples),
        .out_ctrl(out_ctrl), .out_lanes(out_lanes), .out_lane_used(out_lane_used),
        .out_frame_start(out_frame_start), .out_overrun(out_overrun));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // step past the edge so registered outputs have settled
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task fire(input logic [15:0] b);
        base = b;
        send = 1'b1;
        tick(1);
        send = 1'b0;
    endtask
    task await_start;
        for (int i = 0; i < 8 && out_frame_start !== 1'b1; i++) tick(1);
    endtask
    // five channels over two lanes: lane0 ch0..2, lane1 ch3,4 then padding
    task beats(input logic [15:0] b);
        for (int s = 0; s < 3; s++) begin
            chk(out_frame_start, 32'(s == 0));
            chk(out_ctrl, {1'b1, 8'(s)});
            chk(out_lanes[0], b + 16'(s));
            chk(out_lanes[1], s < 2 ? b + 16'(s + 3) : 16'h0);
            chk(out_lane_used, s < 2 ? 2'b11 : 2'b01);
            tick(1);
            send = 1'b0;
        end
    endtask
    task t_single;
        fire(16'h0100);
        await_start;
        beats(16'h0100);
        chk(out_ctrl, 9'h0);
    endtask
    // second frame lands before the first leaves, so only the newer survives
    task t_overrun;
        tick(1);
        fire(16'h0400);
        fire(16'h0500);
        tick(1);
        chk(out_overrun, 1);
        await_start;
        beats(16'h0500);
    endtask
    task t_stream;
        fire(16'h0200);
        await_start;
        base = 16'h0300;
        send = 1'b1;
        beats(16'h0200);
        beats(16'h0300);
    endtask
    task summarize;
        $display("errors %0d of %0d checks", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // the whole run is under a hundred cycles
    initial begin
        #20000;
        errors++;
        summarize;
    end
    initial begin
        tick(16);
        rst = 1'b0;
        chk({out_ctrl, out_lane_used, out_frame_start}, 32'h0);
        t_single;
        t_overrun;
        t_stream;
        summarize;
    end
endmodule
`default_nettype wire
